/* hdl/ccp_pkg.sv */
// Overview of operation
// - software address writes through configuration register 6 only when enable input high and latch input held high.
// - latch input low passes address pins and parity straight through, continuously.
// - latch input rising edge captures address and parity, later pin changes ignored.
// - latch input high lets a configuration register 5 write capture the address.
// - active-low raw reset clears all flip-flops asynchronously except the interrupt output, which goes high; release sampled to clock.
// - after reset release the core runs in its power-up mode set by the strap input.
// - register 2 can select the tag clock input to advance the time-tag counter.
// - monitored words are tagged with the outside 48-bit, 100 ns, same-clock time value.
// - active-low interrupt output, pulse or level style chosen by register 2.
// - wiring-fault interrupt output is active high and follows the fault input.
// - bus A inhibit input high blocks transmission on bus A.
// - bus B inhibit input high blocks transmission on bus B.
// - trigger rising edge starts the bus controller frame when externally triggered.
// - trigger rising edge starts the word monitor frame when externally triggered.
// - in remote terminal mode the external trigger has no effect.
// - trigger sampled only on cycles with the internal clock enable, 12 to 50 MHz.
// - in remote terminal mode the subsystem flag input sets status word bit 2.
// - strap high powers up as remote terminal with busy set, low as idle controller.
// - strobe rising edge copies the running time tag into the register at 0x15.
// - address has odd parity; wrong parity means broadcast only plus maskable interrupt.
package ccp_pkg;
  typedef enum logic [1:0] {CCP_IDLE, CCP_BC, CCP_RT, CCP_MT} ccp_mode_e;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CLK_FREQ_MHZ = 25;
  // trigger enable rate, must sit in the 12 to 50 MHz band
  localparam int unsigned TRIG_CE_MHZ = 25;
  localparam int unsigned TRIG_CE_DIV = CLK_FREQ_MHZ / TRIG_CE_MHZ;
  // internal time-tag resolution
  localparam int unsigned TT_RES_NS = 1000;
  localparam int unsigned TT_TICK_CYC = TT_RES_NS / CLK_PERIOD_NS;

  localparam logic [15:0] REG_CFG1 = 16'h0001;
  localparam logic [15:0] REG_CFG2 = 16'h0002;
  localparam logic [15:0] REG_IRQ_CLR = 16'h0003;
  localparam logic [15:0] REG_CFG5 = 16'h0005;
  localparam logic [15:0] REG_CFG6 = 16'h0006;
  localparam logic [15:0] REG_LATCHED_TT = 16'h0015;
  localparam logic [15:0] REG_STATUS = 16'h0016;

  localparam int unsigned CFG1_MODE_LSB = 0;
  localparam int unsigned CFG1_BUSY_BIT = 2;
  localparam int unsigned CFG2_TT_EXT_BIT = 0;
  localparam int unsigned CFG2_IRQ_LEVEL_BIT = 1;
  localparam int unsigned CFG2_BC_EXT_BIT = 2;
  localparam int unsigned CFG2_MT_EXT_BIT = 3;
  localparam int unsigned CFG2_PAR_MASK_BIT = 4;
  localparam int unsigned CFG6_PAR_BIT = 5;
  localparam int unsigned STAT_PAR_ERR_BIT = 6;
  localparam int unsigned STAT_IRQ_BIT = 7;

  localparam logic [15:0] CFG2_RESET = 16'h0000;
  localparam logic [15:0] TT_RESET = 16'h0000;
endpackage

/* hdl/ccp_rise_det.sv */
`timescale 1ns/1ps
module ccp_rise_det
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // sample
  input wire logic i_en,
  input wire logic i_sig,
  // result
  output logic o_rise,
  output logic o_prev
);
  logic prev_reg;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      prev_reg <= 1'b0;
    else if (i_en)
      prev_reg <= i_sig;
  end

  assign o_rise = i_en & i_sig & ~prev_reg;
  assign o_prev = prev_reg;
endmodule

/* hdl/ccp_ctrl.sv */
`timescale 1ns/1ps
module ccp_ctrl
  import ccp_pkg::*;
(
  // clock and raw reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic i_cpu_cs,
  input wire logic i_mem_sel,
  input wire logic [15:0] i_cpu_addr,
  input wire logic [1:0] i_cpu_we,
  input wire logic [31:0] i_cpu_data_in,
  output logic [31:0] o_cpu_data_out,
  // terminal address
  input wire logic i_sw_term_addr_enable,
  input wire logic i_term_addr_latch_ctrl,
  input wire logic [4:0] i_term_addr_pins,
  input wire logic i_term_addr_parity,
  output logic [4:0] o_term_addr,
  output logic o_term_addr_parity,
  output logic o_broadcast_only,
  // straps and flags
  input wire logic i_store_interface_powerup,
  input wire logic i_subsystem_flag_set,
  output logic o_core_running,
  output logic [1:0] o_mode,
  output logic o_status_busy,
  output logic o_status_subsys,
  // time tag
  input wire logic i_tag_clk,
  input wire logic i_timestamp_capture_strobe,
  input wire logic [47:0] i_external_timestamp_in,
  input wire logic i_mon_word_stb,
  output logic [47:0] o_mon_word_tag,
  // transmit
  input wire logic i_bus_a_transmit_block,
  input wire logic i_bus_b_transmit_block,
  input wire logic i_tx_req_a,
  input wire logic i_tx_req_b,
  output logic o_bus_a_tx_en,
  output logic o_bus_b_tx_en,
  // triggers
  input wire logic i_ext_trigger,
  output logic o_bc_frame_start,
  output logic o_mt_frame_start,
  // interrupts
  input wire logic i_msg_irq_req,
  input wire logic i_wiring_fault,
  output logic o_core_interrupt_low,
  output logic o_wiring_fault_interrupt
);
  logic rst_meta_reg;
  logic run_reg;
  logic started_reg;
  ccp_mode_e mode_reg;
  logic busy_reg;
  logic [15:0] cfg2_reg;
  logic [4:0] addr_reg;
  logic par_reg;
  logic par_err_reg;
  logic irq_pend_reg;
  logic [15:0] tt_reg;
  logic [15:0] tt_latched_reg;
  logic [7:0] tick_cnt_reg;
  logic [7:0] ce_cnt_reg;
  logic trig_ce;
  logic tt_tick;
  logic latch_rise;
  logic latch_prev;
  logic strobe_rise;
  logic trig_rise;
  logic tag_rise;
  logic wr_cfg1;
  logic wr_cfg2;
  logic wr_clr;
  logic wr_cfg5;
  logic wr_cfg6;
  logic addr_par_bad;
  logic irq_event;
  logic [4:0] sw_addr_w;

  function automatic logic reg_wr(input logic [15:0] idx);
    reg_wr = i_cpu_cs & ~i_mem_sel & (i_cpu_addr[15:1] == idx[15:1]) & i_cpu_we[idx[0]];
  endfunction

  function automatic logic [15:0] reg_rd(input logic [15:0] idx);
    reg_rd = 16'h0000;
    unique case (idx)
      REG_CFG1: reg_rd = {13'h0000, busy_reg, mode_reg};
      REG_CFG2: reg_rd = cfg2_reg;
      REG_LATCHED_TT: reg_rd = tt_latched_reg;
      REG_STATUS: reg_rd = {8'h00, irq_pend_reg, par_err_reg, par_reg, addr_reg};
      default: reg_rd = 16'h0000;
    endcase
  endfunction

  assign wr_cfg1 = reg_wr(REG_CFG1);
  assign wr_cfg2 = reg_wr(REG_CFG2);
  assign wr_clr = reg_wr(REG_IRQ_CLR);
  assign wr_cfg5 = reg_wr(REG_CFG5);
  assign wr_cfg6 = reg_wr(REG_CFG6);
  // cfg5 is an odd word, cfg6 even, so cfg6 data sits in the low half
  assign sw_addr_w = i_cpu_data_in[4:0];

  // all flops but the interrupt output (set high) clear on the raw reset; operation waits for the clocked release
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_reg <= 1'b0;
      run_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      run_reg <= rst_meta_reg;
    end
  end

  ccp_rise_det u_latch_det (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(1'b1),
    .i_sig(i_term_addr_latch_ctrl),
    .o_rise(latch_rise),
    .o_prev(latch_prev)
  );

  ccp_rise_det u_strobe_det (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(1'b1),
    .i_sig(i_timestamp_capture_strobe),
    .o_rise(strobe_rise),
    .o_prev()
  );

  ccp_rise_det u_tag_det (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(1'b1),
    .i_sig(i_tag_clk),
    .o_rise(tag_rise),
    .o_prev()
  );

  // trigger only seen on enable cycles, so its edge is judged at that rate
  ccp_rise_det u_trig_det (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(trig_ce),
    .i_sig(i_ext_trigger),
    .o_rise(trig_rise),
    .o_prev()
  );

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ce_cnt_reg <= 8'h00;
    else if (trig_ce)
      ce_cnt_reg <= 8'h00;
    else
      ce_cnt_reg <= ce_cnt_reg + 8'h01;
  end
  assign trig_ce = (ce_cnt_reg == 8'(TRIG_CE_DIV - 1));

  // mode and busy: strap taken on the first cycle after the clocked release, once run_reg is high
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      started_reg <= 1'b0;
      mode_reg <= CCP_IDLE;
      busy_reg <= 1'b0;
    end
    else if (run_reg && !started_reg)
    begin
      started_reg <= 1'b1;
      mode_reg <= i_store_interface_powerup ? CCP_RT : CCP_IDLE;
      busy_reg <= i_store_interface_powerup;
    end
    else if (wr_cfg1)
    begin
      mode_reg <= ccp_mode_e'(i_cpu_data_in[16 + CFG1_MODE_LSB +: 2]);
      busy_reg <= i_cpu_data_in[16 + CFG1_BUSY_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg2_reg <= CFG2_RESET;
    else if (wr_cfg2)
      cfg2_reg <= i_cpu_data_in[15:0];
  end

  // terminal address: pins follow while latch low; latch high holds except on its rise, a cfg5 write or an enabled cfg6 write
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      addr_reg <= 5'h00;
      par_reg <= 1'b0;
    end
    else if (!i_term_addr_latch_ctrl || latch_rise || wr_cfg5)
    begin
      addr_reg <= i_term_addr_pins;
      par_reg <= i_term_addr_parity;
    end
    else if (wr_cfg6 && i_sw_term_addr_enable)
    begin
      addr_reg <= sw_addr_w;
      par_reg <= i_cpu_data_in[CFG6_PAR_BIT];
    end
  end

  // six bits together must hold an odd number of ones
  assign addr_par_bad = ~(^{addr_reg, par_reg});

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      par_err_reg <= 1'b0;
    else
      par_err_reg <= addr_par_bad;
  end

  assign irq_event = i_msg_irq_req |
    (addr_par_bad & ~par_err_reg & ~cfg2_reg[CFG2_PAR_MASK_BIT]);

  // a new event in the clear cycle wins over the clear
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      irq_pend_reg <= 1'b0;
    else if (irq_event)
      irq_pend_reg <= 1'b1;
    else if (wr_clr)
      irq_pend_reg <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_core_interrupt_low <= 1'b1;
    else if (cfg2_reg[CFG2_IRQ_LEVEL_BIT])
      o_core_interrupt_low <= ~(irq_pend_reg | irq_event);
    else
      o_core_interrupt_low <= ~irq_event;
  end

  // no filtering: a flapping wire shows as a flapping line
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_wiring_fault_interrupt <= 1'b0;
    else
      o_wiring_fault_interrupt <= i_wiring_fault;
  end

  // time tag counter, internal tick or outside tag clock
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_cnt_reg <= 8'h00;
    else if (tt_tick)
      tick_cnt_reg <= 8'h00;
    else
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
  end
  assign tt_tick = (tick_cnt_reg == 8'(TT_TICK_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tt_reg <= TT_RESET;
    else if (cfg2_reg[CFG2_TT_EXT_BIT] ? tag_rise : tt_tick)
      tt_reg <= tt_reg + 16'h0001;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tt_latched_reg <= TT_RESET;
    else if (strobe_rise)
      tt_latched_reg <= tt_reg;
  end

  // outside value is already on this clock, so it is taken as is
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_mon_word_tag <= 48'h000000000000;
    else if (i_mon_word_stb)
      o_mon_word_tag <= i_external_timestamp_in;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bus_a_tx_en <= 1'b0;
      o_bus_b_tx_en <= 1'b0;
    end
    else
    begin
      o_bus_a_tx_en <= run_reg & i_tx_req_a & ~i_bus_a_transmit_block;
      o_bus_b_tx_en <= run_reg & i_tx_req_b & ~i_bus_b_transmit_block;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_bc_frame_start <= 1'b0;
      o_mt_frame_start <= 1'b0;
    end
    else
    begin
      o_bc_frame_start <= run_reg & trig_rise & (mode_reg == CCP_BC) &
        cfg2_reg[CFG2_BC_EXT_BIT];
      o_mt_frame_start <= run_reg & trig_rise & (mode_reg == CCP_MT) &
        cfg2_reg[CFG2_MT_EXT_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_status_subsys <= 1'b0;
    else
      o_status_subsys <= (mode_reg == CCP_RT) & i_subsystem_flag_set;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cpu_data_out <= 32'h00000000;
    else if (i_cpu_cs && !i_mem_sel)
      o_cpu_data_out <= {reg_rd({i_cpu_addr[15:1], 1'b1}), reg_rd({i_cpu_addr[15:1], 1'b0})};
    else
      o_cpu_data_out <= 32'h00000000;
  end

  assign o_term_addr = addr_reg;
  assign o_term_addr_parity = par_reg;
  assign o_broadcast_only = par_err_reg;
  assign o_core_running = run_reg;
  assign o_mode = mode_reg;
  assign o_status_busy = busy_reg;

  chk_sw_addr_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_cfg6 && i_sw_term_addr_enable && latch_prev && i_term_addr_latch_ctrl)
    |=> (o_term_addr == $past(sw_addr_w)))
    else $error("software address write not applied");

  chk_sw_addr_block: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (latch_prev && i_term_addr_latch_ctrl && !wr_cfg5 &&
     !(wr_cfg6 && i_sw_term_addr_enable)) |=> $stable(o_term_addr))
    else $error("held terminal address changed");

  chk_addr_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_term_addr_latch_ctrl |=> (o_term_addr == $past(i_term_addr_pins)) &&
    (o_term_addr_parity == $past(i_term_addr_parity)))
    else $error("address not following pins");

  chk_cfg5_latch: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_term_addr_latch_ctrl && (wr_cfg5 || !latch_prev))
    |=> (o_term_addr == $past(i_term_addr_pins)))
    else $error("address not captured");

  chk_tag_ext_clock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cfg2_reg[CFG2_TT_EXT_BIT] && !tag_rise) |=> $stable(tt_reg))
    else $error("time tag moved without tag clock edge");

  chk_strobe_copy: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    strobe_rise |=> (tt_latched_reg == $past(tt_reg)))
    else $error("latched time tag wrong");

  chk_stamp_take: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_mon_word_stb |=> (o_mon_word_tag == $past(i_external_timestamp_in)))
    else $error("monitor tag not taken");

  chk_irq_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_msg_irq_req |=> !o_core_interrupt_low)
    else $error("interrupt not asserted");

  chk_fault_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_wiring_fault |=> o_wiring_fault_interrupt ##1 (o_wiring_fault_interrupt == $past(i_wiring_fault)))
    else $error("wiring fault output not following");

  chk_bus_inhibit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_bus_a_transmit_block || i_bus_b_transmit_block) |=>
    !($past(i_bus_a_transmit_block) && o_bus_a_tx_en) &&
    !($past(i_bus_b_transmit_block) && o_bus_b_tx_en))
    else $error("transmit while inhibited");

  chk_rt_no_trigger: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_reg == CCP_RT) |=> !o_bc_frame_start && !o_mt_frame_start)
    else $error("trigger acted in terminal mode");

  chk_bc_trigger: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_reg && trig_rise && mode_reg == CCP_BC && cfg2_reg[CFG2_BC_EXT_BIT])
    |=> o_bc_frame_start ##1 !o_bc_frame_start)
    else $error("controller frame start missing");

  chk_subsys_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (mode_reg != CCP_RT) |=> !o_status_subsys)
    else $error("subsystem flag outside terminal mode");

  chk_powerup_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (run_reg && !started_reg && i_store_interface_powerup)
    |=> (mode_reg == CCP_RT) && busy_reg)
    else $error("strap power-up mode wrong");
endmodule

/* sim/ccp_host_model.sv */
`timescale 1ns/1ps
module ccp_host_model
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  output logic o_cpu_cs,
  output logic o_mem_sel,
  output logic [15:0] o_cpu_addr,
  output logic [1:0] o_cpu_we,
  output logic [31:0] o_cpu_data_in,
  input wire logic [31:0] i_cpu_data_out,
  // time source
  output logic [47:0] o_timestamp
);
  logic [47:0] ns_reg;

  initial
  begin
    o_cpu_cs = 1'b0;
    o_mem_sel = 1'b0;
    o_cpu_addr = 16'h0000;
    o_cpu_we = 2'b00;
    o_cpu_data_in = 32'h0000_0000;
  end

  // the stamp runs from the core clock itself, so no crossing is needed
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      ns_reg <= 48'h0;
    else
      ns_reg <= ns_reg + 48'(CLK_PERIOD_NS);
  end

  // 100 ns units
  assign o_timestamp = ns_reg / 48'd100;

  // requests change only on the falling edge, held over the taking edge
  task automatic wr(input logic [15:0] addr, input logic [1:0] we, input logic [31:0] data);
    @(negedge i_clk);
    o_cpu_cs = 1'b1;
    o_cpu_addr = addr;
    o_cpu_we = we;
    o_cpu_data_in = data;
    @(negedge i_clk);
    o_cpu_cs = 1'b0;
    o_cpu_we = 2'b00;
    // released data must not look like the last value
    o_cpu_data_in = ~data;
  endtask

  task automatic rd(input logic [15:0] addr, output logic [31:0] data);
    @(negedge i_clk);
    o_cpu_cs = 1'b1;
    o_cpu_addr = addr;
    o_cpu_we = 2'b00;
    @(negedge i_clk);
    data = i_cpu_data_out;
    o_cpu_cs = 1'b0;
  endtask
endmodule

/* sim/tb_core_control_pins_time_tag.sv */
`timescale 1ns/1ps
`define CHK(nm, want, got) \
  begin \
    total_checks++; \
    if ((got) !== (want)) \
    begin \
      err_total++; \
      $display("wrong value %s expected %0h seen %0h", nm, (want), (got)); \
    end \
  end
module tb_core_control_pins_time_tag
  import ccp_pkg::*;
;
  int err_total = 0;
  int total_checks = 0;
  logic clk = 1'b0;
  logic rst_n, sw_en, latch, par, strap, flag, tag_clk, strobe, mon_stb;
  logic blk_a, blk_b, req_a, req_b, trig, irq_req, fault;
  logic cs, msel, ta_par, bc_only, running, busy, subsys;
  logic tx_a, tx_b, bc_go, mt_go, irq_n, fault_irq;
  logic [4:0] pins, ta;
  logic [15:0] addr;
  logic [1:0] we, mode;
  logic [31:0] din, dout;
  logic [47:0] ts, mon_tag;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  ccp_host_model u_host (
    .i_clk(clk), .i_rst_n(rst_n), .o_cpu_cs(cs), .o_mem_sel(msel), .o_cpu_addr(addr),
    .o_cpu_we(we), .o_cpu_data_in(din), .i_cpu_data_out(dout), .o_timestamp(ts)
  );

  ccp_ctrl u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_cpu_cs(cs), .i_mem_sel(msel), .i_cpu_addr(addr),
    .i_cpu_we(we), .i_cpu_data_in(din), .o_cpu_data_out(dout),
    .i_sw_term_addr_enable(sw_en), .i_term_addr_latch_ctrl(latch), .i_term_addr_pins(pins),
    .i_term_addr_parity(par), .o_term_addr(ta), .o_term_addr_parity(ta_par),
    .o_broadcast_only(bc_only), .i_store_interface_powerup(strap),
    .i_subsystem_flag_set(flag), .o_core_running(running), .o_mode(mode),
    .o_status_busy(busy), .o_status_subsys(subsys), .i_tag_clk(tag_clk),
    .i_timestamp_capture_strobe(strobe), .i_external_timestamp_in(ts),
    .i_mon_word_stb(mon_stb), .o_mon_word_tag(mon_tag), .i_bus_a_transmit_block(blk_a),
    .i_bus_b_transmit_block(blk_b), .i_tx_req_a(req_a), .i_tx_req_b(req_b),
    .o_bus_a_tx_en(tx_a), .o_bus_b_tx_en(tx_b), .i_ext_trigger(trig),
    .o_bc_frame_start(bc_go), .o_mt_frame_start(mt_go), .i_msg_irq_req(irq_req),
    .i_wiring_fault(fault), .o_core_interrupt_low(irq_n), .o_wiring_fault_interrupt(fault_irq)
  );

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // samples first, then steps, so the cycle just launched is counted
  task automatic count(input int n, output int lo, output int bc, output int mt);
    lo = 0;
    bc = 0;
    mt = 0;
    repeat (n)
    begin
      lo += (irq_n === 1'b0);
      bc += (bc_go === 1'b1);
      mt += (mt_go === 1'b1);
      @(negedge clk);
    end
  endtask

  task automatic do_reset(input logic s);
    rst_n = 1'b0;
    strap = s;
    cyc(12);
    `CHK("irq in reset", 1'b1, irq_n)
    `CHK("mode in reset", 2'(CCP_IDLE), mode)
    rst_n = 1'b1;
    cyc(4);
  endtask

  task automatic t_powerup;
    do_reset(1'b1);
    `CHK("running", 1'b1, running)
    `CHK("strap mode", 2'(CCP_RT), mode)
    `CHK("strap busy", 1'b1, busy)
    do_reset(1'b0);
    `CHK("idle mode", 2'(CCP_IDLE), mode)
    `CHK("idle busy", 1'b0, busy)
  endtask

  task automatic t_addr;
    int lo, b, m;
    logic [31:0] s;
    latch = 1'b0;
    pins = 5'h14;
    par = ~(^pins);
    cyc(3);
    `CHK("follow addr", 5'h14, ta)
    `CHK("follow parity", 1'b1, ta_par)
    `CHK("good parity", 1'b0, bc_only)
    pins = 5'h03;
    par = ~(^pins);
    cyc(3);
    `CHK("follow again", 5'h03, ta)
    latch = 1'b1;
    cyc(1);
    pins = 5'h07;
    par = ~(^pins);
    cyc(3);
    `CHK("held addr", 5'h03, ta)
    u_host.wr(REG_CFG5, 2'b10, 32'h0);
    cyc(2);
    `CHK("cfg5 addr", 5'h07, ta)
    sw_en = 1'b0;
    u_host.wr(REG_CFG6, 2'b01, 32'h0000_0029);
    cyc(2);
    `CHK("sw addr off", 5'h07, ta)
    sw_en = 1'b1;
    u_host.wr(REG_CFG6, 2'b01, 32'h0000_0029);
    cyc(2);
    `CHK("sw addr on", 5'h09, ta)
    u_host.wr(REG_CFG6, 2'b01, 32'h0000_0009);
    count(6, lo, b, m);
    `CHK("bad parity", 1'b1, bc_only)
    `CHK("parity irq", 1, lo)
    u_host.rd(REG_STATUS, s);
    `CHK("status word", 16'h00C9, s[15:0])
    u_host.wr(REG_CFG6, 2'b01, 32'h0000_0029);
    u_host.wr(REG_CFG2, 2'b01, 32'h0000_0010);
    u_host.wr(REG_CFG6, 2'b01, 32'h0000_0009);
    count(6, lo, b, m);
    `CHK("masked parity irq", 0, lo)
    u_host.wr(REG_CFG6, 2'b01, 32'h0000_0029);
    u_host.wr(REG_CFG2, 2'b01, 32'h0);
  endtask

  task automatic t_irq;
    int lo, b, m;
    irq_req = 1'b1;
    cyc(1);
    irq_req = 1'b0;
    count(5, lo, b, m);
    `CHK("pulse irq", 1, lo)
    // drop what earlier events left pending, so the level check sees only this request
    u_host.wr(REG_IRQ_CLR, 2'b10, 32'h0);
    u_host.wr(REG_CFG2, 2'b01, 32'h0000_0002);
    cyc(2);
    `CHK("level idle", 1'b1, irq_n)
    irq_req = 1'b1;
    cyc(1);
    irq_req = 1'b0;
    count(8, lo, b, m);
    `CHK("level irq", 8, lo)
    u_host.wr(REG_IRQ_CLR, 2'b10, 32'h0);
    cyc(2);
    `CHK("irq cleared", 1'b1, irq_n)
    u_host.wr(REG_CFG2, 2'b01, 32'h0);
  endtask

  task automatic t_tx;
    req_a = 1'b1;
    req_b = 1'b1;
    blk_a = 1'b1;
    cyc(2);
    `CHK("tx a blocked", 1'b0, tx_a)
    `CHK("tx b free", 1'b1, tx_b)
    blk_a = 1'b0;
    blk_b = 1'b1;
    cyc(2);
    `CHK("tx a free", 1'b1, tx_a)
    `CHK("tx b blocked", 1'b0, tx_b)
    blk_b = 1'b0;
    req_a = 1'b0;
    req_b = 1'b0;
  endtask

  // last entry is controller mode with its external start switched off
  task automatic t_trig;
    logic [1:0] md [4] = '{2'(CCP_BC), 2'(CCP_MT), 2'(CCP_RT), 2'(CCP_BC)};
    logic [15:0] c2 [4] = '{16'h000C, 16'h000C, 16'h000C, 16'h0008};
    int lo, b, m;
    flag = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(REG_CFG1, 2'b10, {14'h0, md[i], 16'h0});
      u_host.wr(REG_CFG2, 2'b01, {16'h0, c2[i]});
      trig = 1'b1;
      count(5, lo, b, m);
      trig = 1'b0;
      `CHK("bc starts", (i == 0) ? 1 : 0, b)
      `CHK("mt starts", (i == 1) ? 1 : 0, m)
      `CHK("subsys bit", md[i] == 2'(CCP_RT), subsys)
    end
    flag = 1'b0;
    u_host.wr(REG_CFG2, 2'b01, 32'h0);
  endtask

  task automatic t_tt;
    logic [31:0] a, b;
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    u_host.rd(REG_LATCHED_TT, a);
    cyc(47);
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    u_host.rd(REG_LATCHED_TT, b);
    `CHK("tt step", 16'(50 / TT_TICK_CYC), 16'(b[31:16] - a[31:16]))
    `CHK("even half", 16'h0, b[15:0])
    u_host.wr(REG_CFG2, 2'b01, 32'h0000_0001);
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    u_host.rd(REG_LATCHED_TT, a);
    repeat (3)
    begin
      tag_clk = 1'b1;
      cyc(2);
      tag_clk = 1'b0;
      cyc(2);
    end
    cyc(2);
    strobe = 1'b1;
    cyc(1);
    strobe = 1'b0;
    u_host.rd(REG_LATCHED_TT, b);
    `CHK("ext tt step", 16'h0003, 16'(b[31:16] - a[31:16]))
    u_host.wr(REG_CFG2, 2'b01, 32'h0);
  endtask

  task automatic t_mon;
    logic [47:0] want;
    want = ts;
    mon_stb = 1'b1;
    cyc(1);
    mon_stb = 1'b0;
    cyc(1);
    `CHK("monitor tag", want, mon_tag)
    fault = 1'b1;
    cyc(1);
    `CHK("fault set", 1'b1, fault_irq)
    fault = 1'b0;
    cyc(1);
    `CHK("fault clear", 1'b0, fault_irq)
    fault = 1'b1;
    cyc(1);
    `CHK("fault again", 1'b1, fault_irq)
    fault = 1'b0;
  endtask

  initial
  begin
    rst_n = 1'b0;
    sw_en = 1'b0;
    latch = 1'b0;
    pins = 5'h00;
    par = 1'b1;
    strap = 1'b0;
    flag = 1'b0;
    tag_clk = 1'b0;
    strobe = 1'b0;
    mon_stb = 1'b0;
    blk_a = 1'b0;
    blk_b = 1'b0;
    req_a = 1'b0;
    req_b = 1'b0;
    trig = 1'b0;
    irq_req = 1'b0;
    fault = 1'b0;
    t_powerup();
    t_addr();
    t_irq();
    t_tx();
    t_trig();
    t_tt();
    t_mon();
    finish_test();
  end

  // a hang costs a mismatch and still reaches the verdict
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule
